//--- tpr_params.svh
/*
 Constants of the temperature PWM and relay output stage.
 Assumes a 125 MHz hclk and an AHB-Lite register slave.
*/
`ifndef TPR_PARAMS_SVH
`define TPR_PARAMS_SVH
`define TPR_CTRL_OFS 8'h00
`define TPR_OBJ_OFS 8'h04
`define TPR_AMB_OFS 8'h08
`define TPR_THR_OFS 8'h0c
`define TPR_HYS_OFS 8'h10
`define TPR_STAT_OFS 8'h14
`define TPR_CTRL_RST 3'h5
`define TPR_THR_RST 12'hd24
`define TPR_HYS_RST 12'h092
`define TPR_CLK_NS 8
`define TPR_TICK_NS 50000
`define TPR_TICK_CYCLES (`TPR_TICK_NS / `TPR_CLK_NS)
`define TPR_FRAME_LAST 11'h7ff
`define TPR_LEAD_TICKS 11'h100
`define TPR_TRAIL_START 11'h700
`define TPR_ERR_TICKS 11'h200
`define TPR_STAT_TICK_POS 16
`define TPR_STAT_PHASE_POS 8
`endif

//--- tpr_pkg.sv
/*
 Types of the temperature PWM and relay output stage.
 Assumes tpr_params.svh for all numeric constants.
*/
package tpr_pkg;
    typedef enum logic [2:0] {
        PH_LEAD = 3'b000,
        PH_HIGH = 3'b001,
        PH_LOW = 3'b010,
        PH_TRAIL = 3'b011,
        PH_ERROR = 3'b100
    } tpr_phase_t;
    typedef struct packed {
        logic pwm_en;
        logic relay_src;
        logic relay_inv;
    } tpr_ctrl_t;
    typedef struct packed {
        logic [11:0] data;
        logic [2:0] flags;
        logic rsvd;
    } tpr_temp_t;
endpackage : tpr_pkg

//--- tpr_top.sv
/*
 Two-channel temperature PWM encoder and hysteresis relay
 comparator with an AHB-Lite register slave.
 Assumes temperatures are written by acquisition firmware and
 an external pull-up on the open-drain relay line.
*/
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "tpr_params.svh"

module tpr_top #(
    parameter int unsigned TICK_CYCLES = `TPR_TICK_CYCLES
) (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // PWM outputs
    output logic obj_pwm_out,
    output logic amb_pwm_out,
    // Open-drain relay driver
    output logic relay_driver_out,
    output logic relay_driver_out_oe
);

    tpr_pkg::tpr_ctrl_t ctrl;
    tpr_pkg::tpr_temp_t temp_reg [2];
    logic [11:0] thr;
    logic [11:0] hys;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [15:0] presc;
    logic tick_en;
    logic [10:0] frame_tick;
    logic frame_end;
    logic [9:0] duty_lat [2];
    logic err_lat [2];
    tpr_pkg::tpr_phase_t phase [2];
    logic pwm_q [2];
    logic above;
    logic relay_q;
    logic [11:0] cmp_src;
    logic [12:0] hi_lim;
    logic [12:0] lo_lim;
    logic lo_ok;
    logic next_above;
    logic [31:0] next_rdata;
    logic take;
    logic wr_ok;

    // Zero-wait slave; a low clock enable stalls the bus
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign take = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else if (ce) begin
            ap_valid <= take && hsize == 3'h2;
            ap_write <= hwrite;
            ap_addr <= haddr[7:0];
        end
    end

    assign wr_ok = ce && ap_valid && ap_write;

    // Control and comparator settings, preset at reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `TPR_CTRL_RST;
            thr <= `TPR_THR_RST;
            hys <= `TPR_HYS_RST;
        end else if (wr_ok) begin
            unique case (ap_addr)
                `TPR_CTRL_OFS: ctrl <= hwdata[2:0];
                `TPR_THR_OFS: thr <= hwdata[11:0];
                `TPR_HYS_OFS: hys <= hwdata[11:0];
                default: ;
            endcase
        end
    end

    // Temperature words: data in 15:4, error flags in 3:1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            temp_reg[0] <= '0;
            temp_reg[1] <= '0;
        end else if (wr_ok) begin
            if (ap_addr == `TPR_OBJ_OFS)
                temp_reg[0] <= {hwdata[15:1], 1'b0};
            if (ap_addr == `TPR_AMB_OFS)
                temp_reg[1] <= {hwdata[15:1], 1'b0};
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr[7:0])
            `TPR_CTRL_OFS: next_rdata[2:0] = ctrl;
            `TPR_OBJ_OFS: next_rdata[15:0] = temp_reg[0];
            `TPR_AMB_OFS: next_rdata[15:0] = temp_reg[1];
            `TPR_THR_OFS: next_rdata[11:0] = thr;
            `TPR_HYS_OFS: next_rdata[11:0] = hys;
            `TPR_STAT_OFS: begin
                next_rdata[0] = relay_q;
                next_rdata[1] = above;
                next_rdata[3:2] = {pwm_q[1], pwm_q[0]};
                next_rdata[`TPR_STAT_PHASE_POS +: 3] = phase[0];
                next_rdata[`TPR_STAT_TICK_POS +: 11] = frame_tick;
            end
            default: ;
        endcase
    end

    // Read data stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ce && take && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // PWM time base
    assign tick_en = presc == 16'(TICK_CYCLES - 1);
    assign frame_end = tick_en && frame_tick == `TPR_FRAME_LAST;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc <= 16'h0000;
        end else if (ce) begin
            presc <= tick_en ? 16'h0000 : presc + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_tick <= 11'h000;
        end else if (ce && tick_en) begin
            frame_tick <= frame_tick + 11'h001;
        end
    end

    // Per-channel frame encoder; channel 0 object, 1 ambient
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic [10:0] high_end;
        assign high_end = {1'b0, duty_lat[ch]} + `TPR_LEAD_TICKS;

        // Sample once per frame so a frame is never torn
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                duty_lat[ch] <= 10'h000;
                err_lat[ch] <= 1'b0;
            end else if (ce && frame_end) begin
                duty_lat[ch] <= temp_reg[ch].data[11:2];
                err_lat[ch] <= |temp_reg[ch].flags;
            end
        end

        // Error frame: high through the first quarter, then low
        always_comb begin
            if (err_lat[ch])
                phase[ch] = frame_tick < `TPR_ERR_TICKS ? tpr_pkg::PH_ERROR : tpr_pkg::PH_LOW;
            else if (frame_tick < `TPR_LEAD_TICKS)
                phase[ch] = tpr_pkg::PH_LEAD;
            else if (frame_tick < high_end)
                phase[ch] = tpr_pkg::PH_HIGH;
            else if (frame_tick < `TPR_TRAIL_START)
                phase[ch] = tpr_pkg::PH_LOW;
            else
                phase[ch] = tpr_pkg::PH_TRAIL;
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pwm_q[ch] <= 1'b0;
            end else if (ce) begin
                unique case (phase[ch])
                    tpr_pkg::PH_HIGH, tpr_pkg::PH_ERROR: pwm_q[ch] <= ctrl.pwm_en;
                    tpr_pkg::PH_LEAD, tpr_pkg::PH_LOW, tpr_pkg::PH_TRAIL: pwm_q[ch] <= 1'b0;
                    default: pwm_q[ch] <= 1'b0;
                endcase
            end
        end
    end

    assign obj_pwm_out = pwm_q[0];
    assign amb_pwm_out = pwm_q[1];

    // Relay comparator with hysteresis band
    assign cmp_src = ctrl.relay_src ? temp_reg[1].data : temp_reg[0].data;
    assign hi_lim = {1'b0, thr} + {1'b0, hys};
    assign lo_lim = {1'b0, thr} - {1'b0, hys};
    // Lower crossing only while the band stays above code zero
    assign lo_ok = thr >= hys;

    always_comb begin
        next_above = above;
        if ({1'b0, cmp_src} > hi_lim)
            next_above = 1'b1;
        else if (lo_ok && {1'b0, cmp_src} < lo_lim)
            next_above = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            above <= 1'b0;
        end else if (ce) begin
            above <= next_above;
        end
    end

    // Driver pulls low while the relay is on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            relay_q <= 1'b0;
        end else if (ce) begin
            relay_q <= ctrl.relay_inv ? !above : above;
        end
    end

    assign relay_driver_out = 1'b0;
    assign relay_driver_out_oe = relay_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    frame_wrap_a: assert property (ce && frame_end |=> frame_tick == 11'h000)
        else $error("frame counter did not wrap");
    lead_low_a: assert property (ce && !err_lat[0] && frame_tick < 11'h100 |=> !obj_pwm_out)
        else $error("lead buffer not low");
    trail_low_a: assert property (ce && !err_lat[1] && frame_tick >= 11'h700 |=> !amb_pwm_out)
        else $error("trail buffer not low");
    high_part_a: assert property (ce && ctrl.pwm_en && !err_lat[0] && frame_tick >= 11'h100
        && frame_tick < 11'h100 + {1'b0, duty_lat[0]} |=> obj_pwm_out)
        else $error("high portion missing");
    low_part_a: assert property (ce && !err_lat[0] && frame_tick < 11'h700
        && frame_tick >= 11'h100 + {1'b0, duty_lat[0]} |=> !obj_pwm_out)
        else $error("low portion not low");
    err_pattern_a: assert property (ce && ctrl.pwm_en && err_lat[0]
        |=> obj_pwm_out == ($past(frame_tick) < 11'h200))
        else $error("error pattern wrong");
    duty_latch_a: assert property (ce && frame_end |=> duty_lat[0] == $past(temp_reg[0].data[11:2]))
        else $error("duty not sampled at frame end");
    relay_inv_a: assert property (ce && ctrl.relay_inv && above |=> !relay_driver_out_oe)
        else $error("inverting relay on above threshold");
    relay_non_a: assert property (ce && !ctrl.relay_inv && above |=> relay_driver_out_oe)
        else $error("non-inverting relay off above threshold");
    hyst_band_a: assert property (ce && {1'b0, cmp_src} > hi_lim |=> above)
        else $error("comparator missed upper crossing");

    // Time base
    presc_range_a: assert property (presc < 16'(TICK_CYCLES))
        else $error("prescaler out of range");
    tick_step_a: assert property (ce && tick_en
        |=> frame_tick == $past(frame_tick) + 11'h001)
        else $error("frame counter did not step");

    // Ambient frame shape and the remaining object buffer
    amb_lead_a: assert property (ce && !err_lat[1] && frame_tick < `TPR_LEAD_TICKS
        |=> !amb_pwm_out)
        else $error("ambient lead buffer not low");
    obj_trail_a: assert property (ce && !err_lat[0] && frame_tick >= `TPR_TRAIL_START
        |=> !obj_pwm_out)
        else $error("object trail buffer not low");
    amb_high_a: assert property (ce && ctrl.pwm_en && !err_lat[1] && frame_tick >= `TPR_LEAD_TICKS
        && frame_tick < `TPR_LEAD_TICKS + {1'b0, duty_lat[1]} |=> amb_pwm_out)
        else $error("ambient high portion missing");
    amb_low_a: assert property (ce && !err_lat[1] && frame_tick < `TPR_TRAIL_START
        && frame_tick >= `TPR_LEAD_TICKS + {1'b0, duty_lat[1]} |=> !amb_pwm_out)
        else $error("ambient low portion not low");
    amb_err_a: assert property (ce && ctrl.pwm_en && err_lat[1]
        |=> amb_pwm_out == ($past(frame_tick) < `TPR_ERR_TICKS))
        else $error("ambient error pattern wrong");
    pwm_off_a: assert property (ce && !ctrl.pwm_en
        |=> !obj_pwm_out && !amb_pwm_out)
        else $error("disabled output not low");

    // Frame-end sampling
    amb_latch_a: assert property (ce && frame_end
        |=> duty_lat[1] == $past(temp_reg[1].data[11:2]))
        else $error("ambient duty not sampled at frame end");
    err_latch_a: assert property (ce && frame_end
        |=> err_lat[0] == (|$past(temp_reg[0].flags)))
        else $error("error flag not sampled at frame end");

    // Register writes land one edge after the data phase
    ctrl_write_a: assert property (wr_ok && ap_addr == `TPR_CTRL_OFS
        |=> ctrl == $past(hwdata[2:0]))
        else $error("control write lost");
    thr_write_a: assert property (wr_ok && ap_addr == `TPR_THR_OFS
        |=> thr == $past(hwdata[11:0]))
        else $error("threshold write lost");
    hys_write_a: assert property (wr_ok && ap_addr == `TPR_HYS_OFS
        |=> hys == $past(hwdata[11:0]))
        else $error("hysteresis write lost");
    obj_write_a: assert property (wr_ok && ap_addr == `TPR_OBJ_OFS
        |=> temp_reg[0] == {$past(hwdata[15:1]), 1'b0})
        else $error("object temperature write lost");
    amb_write_a: assert property (wr_ok && ap_addr == `TPR_AMB_OFS
        |=> temp_reg[1] == {$past(hwdata[15:1]), 1'b0})
        else $error("ambient temperature write lost");

    // Read data of the address phase
    read_ctrl_a: assert property (ce && take && !hwrite && haddr[7:0] == `TPR_CTRL_OFS
        |=> hrdata == {29'h0, $past(ctrl)})
        else $error("control read wrong");
    read_thr_a: assert property (ce && take && !hwrite && haddr[7:0] == `TPR_THR_OFS
        |=> hrdata == {20'h0_0000, $past(thr)})
        else $error("threshold read wrong");
    read_obj_a: assert property (ce && take && !hwrite && haddr[7:0] == `TPR_OBJ_OFS
        |=> hrdata == {16'h0000, $past(temp_reg[0])})
        else $error("object temperature read wrong");

    // Comparator and relay driver
    hyst_low_a: assert property (ce && lo_ok && {1'b0, cmp_src} < lo_lim
        |=> !above)
        else $error("comparator missed lower crossing");
    hyst_hold_a: assert property (ce && {1'b0, cmp_src} <= hi_lim && !(lo_ok && {1'b0, cmp_src} < lo_lim)
        |=> above == $past(above))
        else $error("comparator moved inside band");
    relay_inv_on_a: assert property (ce && ctrl.relay_inv && !above
        |=> relay_driver_out_oe)
        else $error("inverting relay off below threshold");
    relay_non_off_a: assert property (ce && !ctrl.relay_inv && !above
        |=> !relay_driver_out_oe)
        else $error("non-inverting relay on below threshold");

    frame_end_c: cover property (ce && frame_end);
    error_frame_c: cover property (ce && err_lat[0] && frame_end);
    relay_on_c: cover property (ce && $rose(relay_driver_out_oe));
    full_duty_c: cover property (duty_lat[0] == 10'h3ff && obj_pwm_out);
    relay_off_c: cover property (ce && $fell(relay_driver_out_oe));

endmodule : tpr_top

//--- tpr_mcu_model.sv
/*
 Far-side microcontroller model: times the PWM pulses and reads the relay line.
 Assumes an external pull-up on the open-drain relay line.
*/
`timescale 1ns/1ps

module tpr_mcu_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Lines from the device, {ambient, object}
    input wire logic [1:0] pwm,
    input wire logic relay_drv,
    input wire logic relay_oe,
    // Serial select, never asserted here
    output logic serial_select_n,
    // Captured values
    output logic relay_level,
    output logic [15:0] high_len [2],
    output logic [15:0] period,
    output logic [15:0] rises [2]
);
    logic [1:0] prev;
    logic [15:0] hcnt [2];
    logic [15:0] since;

    // Pull-up wins while the driver is released
    assign relay_level = relay_oe ? relay_drv : 1'b1;

    // No serial engine: the device stays deselected
    assign serial_select_n = 1'b1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev <= 2'h0;
            since <= 16'h0;
            period <= 16'h0;
            for (int i = 0; i < 2; i++) begin
                hcnt[i] <= 16'h0;
                high_len[i] <= 16'h0;
                rises[i] <= 16'h0;
            end
        end else begin
            prev <= pwm;
            since <= (pwm[0] && !prev[0]) ? 16'h1 : since + 16'h1;
            if (pwm[0] && !prev[0]) begin
                period <= since;
            end
            for (int i = 0; i < 2; i++) begin
                if (pwm[i]) begin
                    hcnt[i] <= prev[i] ? hcnt[i] + 16'h1 : 16'h1;
                end
                if (pwm[i] && !prev[i]) begin
                    rises[i] <= rises[i] + 16'h1;
                end
                if (!pwm[i] && prev[i]) begin
                    high_len[i] <= hcnt[i];
                end
            end
        end
    end
endmodule : tpr_mcu_model

//--- tb_temp_pwm_relay_outputs.sv
/*
 Testbench of tpr_top: register reset values, relay comparator, PWM frames.
 Assumes tpr_mcu_model on the far side and ce held high.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module tb_temp_pwm_relay_outputs;
    localparam int TICKS = 4;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, obj_pwm_out, amb_pwm_out, relay_driver_out, relay_driver_out_oe, relay_level;
    logic serial_select_n;
    logic [15:0] high_len [2];
    logic [15:0] rises [2];
    logic [15:0] period, r0, r1;
    int failures = 0;
    int checks = 0;

    always #4 hclk = ~hclk;

    tpr_top #(.TICK_CYCLES(TICKS)) u_tpr_top (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .obj_pwm_out(obj_pwm_out),
        .amb_pwm_out(amb_pwm_out), .relay_driver_out(relay_driver_out), .relay_driver_out_oe(relay_driver_out_oe));
    tpr_mcu_model u_tpr_mcu_model (.hclk(hclk), .hresetn(hresetn), .pwm({amb_pwm_out, obj_pwm_out}),
        .relay_drv(relay_driver_out), .relay_oe(relay_driver_out_oe), .relay_level(relay_level),
        .serial_select_n(serial_select_n),
        .high_len(high_len), .period(period), .rises(rises));

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            failures++;
            complete_run();
        end
    endtask : wait_ready

    // One single word transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : xfer

    task automatic relay_step(input logic [7:0] ofs, input logic [31:0] wd, input logic lvl);
        xfer(1'b1, ofs, wd);
        repeat (3) @(posedge hclk);
        `CHK("relay level", lvl, relay_level)
    endtask : relay_step

    // Three object frames so the new codes are in force
    task automatic wait_frames();
        int n;
        n = 0;
        r0 = rises[0];
        while (rises[0] !== r0 + 16'h3 && n < 40000) begin
            @(posedge hclk);
            n++;
        end
        if (rises[0] !== r0 + 16'h3) begin
            failures++;
            complete_run();
        end
    endtask : wait_frames

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h5, rd)
        xfer(1'b0, 8'h0c, 32'h0);
        `CHK("threshold", 32'hd24, rd)
        xfer(1'b0, 8'h10, 32'h0);
        `CHK("hysteresis", 32'h92, rd)
        xfer(1'b0, 8'h18, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("okay response", 1'b0, hresp)
        `CHK("serial select", 1'b1, serial_select_n)
        $display("test reset done");
        `CHK("relay level", 1'b0, relay_level)
        relay_step(8'h04, 32'hdb60, 1'b0);
        relay_step(8'h04, 32'hdb70, 1'b1);
        relay_step(8'h04, 32'hc920, 1'b1);
        relay_step(8'h04, 32'hc910, 1'b0);
        relay_step(8'h00, 32'h4, 1'b1);
        relay_step(8'h04, 32'hdb70, 1'b0);
        xfer(1'b1, 8'h10, 32'h10);
        relay_step(8'h0c, 32'he00, 1'b1);
        relay_step(8'h00, 32'h5, 1'b0);
        xfer(1'b0, 8'h14, 32'h0);
        `CHK("status relay", 2'h1, rd[1:0])
        $display("test relay done");
        xfer(1'b1, 8'h04, 32'hfff0);
        xfer(1'b1, 8'h08, 32'h4000);
        wait_frames();
        `CHK("obj high", 16'(1023 * TICKS), high_len[0])
        `CHK("amb high", 16'(256 * TICKS), high_len[1])
        `CHK("period", 16'(2048 * TICKS), period)
        $display("test pwm done");
        xfer(1'b1, 8'h04, 32'h4002);
        xfer(1'b1, 8'h08, 32'h1000);
        wait_frames();
        `CHK("error high", 16'(512 * TICKS), high_len[0])
        `CHK("amb high", 16'(64 * TICKS), high_len[1])
        `CHK("period", 16'(2048 * TICKS), period)
        $display("test error done");
        xfer(1'b1, 8'h00, 32'h1);
        repeat (3) @(posedge hclk);
        r0 = rises[0];
        r1 = rises[1];
        repeat (9000) @(posedge hclk);
        `CHK("obj rises", r0, rises[0])
        `CHK("amb rises", r1, rises[1])
        $display("test disable done");
        complete_run();
    end
endmodule : tb_temp_pwm_relay_outputs
